// file: pkg/dwc_pkg.sv
// Purpose: Shared constants for the dual watch and configuration controller.
// Assumes: 25 MHz system clock, APB register access.
// Notes:   Offsets are byte addresses of 32-bit registers.
package dwc_pkg;
    // Clock frequency in Hz.
    localparam int unsigned CLK_HZ        = 25000000;
    // Set key hold time before the menu opens, in seconds.
    localparam int unsigned MENU_HOLD_S   = 5;
    localparam int unsigned MENU_HOLD_CYC = MENU_HOLD_S * CLK_HZ;
    // Menu inactivity timeout, in seconds.
    localparam int unsigned MENU_TMO_S    = 10;
    localparam int unsigned MENU_TMO_CYC  = MENU_TMO_S * CLK_HZ;
    // Dual watch sampling period and dwell, in milliseconds.
    localparam int unsigned DW_PERIOD_MS  = 2000;
    localparam int unsigned DW_DWELL_MS   = 200;
    localparam int unsigned DW_PERIOD_CYC = DW_PERIOD_MS * (CLK_HZ / 1000);
    localparam int unsigned DW_DWELL_CYC  = DW_DWELL_MS * (CLK_HZ / 1000);
    // Number of menu items.
    localparam logic [3:0]  MENU_ITEMS    = 4'hF;
    // Menu item indices.
    localparam logic [3:0]  ITEM_SPACING  = 4'h0;
    localparam logic [3:0]  ITEM_DISPLAY  = 4'h1;
    localparam logic [3:0]  ITEM_TALK     = 4'h2;
    localparam logic [3:0]  ITEM_ATTEN    = 4'h3;
    // Register byte offsets.
    localparam logic [7:0]  REG_CTRL      = 8'h00;
    localparam logic [7:0]  REG_STATUS    = 8'h04;
    localparam logic [7:0]  REG_FREQ      = 8'h08;
    // Display delay in seconds for codes 1..5.
    localparam int unsigned DISP_S1 = 10;
    localparam int unsigned DISP_S2 = 20;
    localparam int unsigned DISP_S3 = 30;
    localparam int unsigned DISP_S4 = 60;
    localparam int unsigned DISP_S5 = 120;
    // Reset values of settings.
    localparam logic [2:0]  RST_DISPLAY   = 3'h0;
    localparam logic [1:0]  RST_TALK      = 2'h0;
    localparam logic [3:0]  RST_ATTEN     = 4'h0;
    // Talk button selection codes.
    typedef enum logic [1:0] {
        DWC_TALK_ALL   = 2'b00,
        DWC_TALK_ONE   = 2'b01,
        DWC_TALK_LEFT  = 2'b10,
        DWC_TALK_RIGHT = 2'b11
    } dwc_talk_e;
    // Receiver tuning state.
    typedef enum logic [1:0] {
        DWC_RX_ACTIVE  = 2'b00,
        DWC_RX_STANDBY = 2'b01,
        DWC_RX_PEEK    = 2'b10,
        DWC_RX_HOLD    = 2'b11
    } dwc_rx_e;
endpackage : dwc_pkg

// file: tb/dwc_ctrl_test.sv
// Purpose: Self-checking bench for the dual watch controller.
// Assumes: Shortened counts; SEC is the cycles of one second.
// Notes:   Random values from a fixed seed.
`timescale 1ns/10ps
`default_nettype none
module dwc_ctrl_test;
    import dwc_pkg::*;
    localparam int PER = 40, DWL = 8, HOLD = 50, TMO = 100, SEC = 10;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, sq = 0, chg = 0, icm = 0, bad;
    wire logic pk, dk, sk, ak, ck, ku, kd, tl, tr;
    logic rxs, lbl, men, dark, tx, ml, mr, ico, s25, l, r;
    logic [3:0] item, att, a;
    logic [31:0] f;
    int fails = 0, checks = 0, n;
    always #20 pclk = ~pclk;
    dwc_operator i_dwc_operator (.pclk(pclk), .power_key(pk),
        .dual_watch_key(dk), .set_key(sk), .arrow_key(ak), .cursor_key(ck),
        .knob_up(ku), .knob_down(kd), .talk_left(tl), .talk_right(tr));
    dwc_ctrl #(.MENU_HOLD(HOLD), .MENU_TMO(TMO), .DW_PERIOD(PER),
        .DW_DWELL(DWL), .SEC_CYC(SEC)) i_dwc_ctrl (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .power_key(pk), .dual_watch_key(dk),
        .set_key(sk), .arrow_key(ak), .cursor_key(ck), .knob_up(ku),
        .knob_down(kd), .talk_left(tl), .talk_right(tr),
        .intercom_in(icm), .squelch_open(sq), .chan_change(chg),
        .rx_on_standby(rxs), .standby_channel_label(lbl),
        .menu_active(men), .menu_item(item), .display_dark(dark),
        .tx_key(tx), .mic_left_en(ml), .mic_right_en(mr),
        .intercom_out(ico), .standby_atten(att), .spacing_25k(s25));
    ////////////////////////////////////////////////////////////////////
    // Compares one value and reports a mismatch at once.
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s exp %0h got %0h", nm, e, g);
        end
    endtask : chk
    // One APB transfer; holds the request until pready at a rising edge.
    task automatic apb(input logic w, input logic [7:0] ad,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Waits a bounded time for the receiver to reach state v.
    task automatic wait_rx(input logic v, input int lim);
        n = 0;
        while (rxs !== v && n < lim) begin
            @(posedge pclk);
            n++;
        end
        chk("rx_on_standby", v, rxs);
    endtask : wait_rx
    // Expected {tx, left mic, right mic} for a selection and buttons.
    function automatic logic [2:0] talk_exp(int m, logic bl, logic br);
        case (m)
            0: talk_exp = {3{bl | br}};
            1: talk_exp = {bl | br, bl, br};
            2: talk_exp = {bl, bl, 1'b0};
            default: talk_exp = {br, 1'b0, br};
        endcase
    endfunction : talk_exp
    task automatic key(input int k);
        i_dwc_operator.press(k, 4);
        repeat (6) @(posedge pclk);
    endtask : key
    task automatic print_verdict;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////////
    // Watchdog cuts a hang short.
    initial begin
        repeat (30000) @(posedge pclk);
        fails++;
        print_verdict();
    end
    // Main sequence.
    initial begin
        rd = $urandom(5222);
        repeat (4) @(posedge pclk);
        chk("reset outputs", 32'h0, {lbl, men, dark, tx});
        presetn <= 1'b1;
        // Dual watch on, peek and dwell, squelch hold, off.
        key(1);
        chk("label on", 1, lbl);
        wait_rx(1, 10);
        wait_rx(0, PER + 10);
        wait_rx(1, DWL + 3);
        chk("dwell", 1, n >= DWL - 2 && n <= DWL + 1);
        wait_rx(0, PER + 10);
        sq <= 1'b1;
        bad = 0;
        repeat (DWL + 30) begin
            @(posedge pclk);
            bad |= rxs;
        end
        chk("hold active", 0, bad);
        sq <= 1'b0;
        wait_rx(1, 10);
        key(1);
        chk("label off", 0, lbl);
        key(1);
        @(posedge pclk) chg <= 1'b1;
        @(posedge pclk) chg <= 1'b0;
        repeat (6) @(posedge pclk);
        chk("label chan", 0, lbl);
        $display("test dual watch done");
        // Menu entry, item order, exits and timeout.
        i_dwc_operator.press(2, HOLD - 10);
        repeat (6) @(posedge pclk);
        chk("menu short", 0, men);
        i_dwc_operator.press(2, HOLD + 5);
        repeat (6) @(posedge pclk);
        chk("menu open", 1, men);
        chk("item", 0, item);
        i_dwc_operator.press(5, 2);
        repeat (6) @(posedge pclk);
        chk("knob edit", 1, s25);
        for (int i = 1; i < 15; i++) begin
            key(2);
            chk("item", i, item);
        end
        for (int j = 0; j < 4; j++) begin
            key(j == 0 ? 3 : j == 1 ? 0 : j == 2 ? 1 : 4);
            chk("menu exit", 0, men);
            i_dwc_operator.press(2, HOLD + 5);
            repeat (6) @(posedge pclk);
        end
        repeat (TMO - 20) @(posedge pclk);
        chk("menu kept", 1, men);
        repeat (40) @(posedge pclk);
        chk("menu timeout", 0, men);
        @(posedge pclk) chg <= 1'b1;
        @(posedge pclk) chg <= 1'b0;
        $display("test menu done");
        // Talk selection with random buttons and intercom.
        for (int m = 0; m < 4; m++) begin
            apb(1, REG_CTRL, 32'(m) << 4);
            repeat (8) begin
                l = 1'($urandom);
                r = 1'($urandom);
                icm <= 1'($urandom);
                i_dwc_operator.talk(l, r);
                repeat (6) @(posedge pclk);
                chk("talk", talk_exp(m, l, r), {tx, ml, mr});
                chk("intercom", icm, ico);
            end
        end
        i_dwc_operator.talk(0, 0);
        $display("test talk done");
        // Attenuation clamp, spacing and channel acceptance.
        for (int i = 0; i < 10; i++) begin
            a = (i < 2) ? 4'(9 + i) : 4'($urandom);
            apb(1, REG_CTRL, {19'h0, i[0], a, 8'h00});
            repeat (2) @(posedge pclk);
            chk("atten", (a > 9) ? 9 : a, att);
            chk("spacing", i[0], s25);
            f = $urandom & 32'h000FFFFF;
            apb(1, REG_FREQ, f);
            apb(0, REG_FREQ, 0);
            chk("accept", !i[0] || f[1:0] == 2'b00, rd[20]);
        end
        apb(0, 8'h0C, 0);
        chk("unmapped err", 1, err);
        chk("unmapped data", 0, rd);
        $display("test settings done");
        // Display saver, wake sources and waking press.
        apb(1, REG_CTRL, 32'h1);
        repeat (10 * SEC + 20) @(posedge pclk);
        chk("dark", 1, dark);
        key(0);
        chk("power no wake", 1, dark);
        i_dwc_operator.press(5, 2);
        repeat (6) @(posedge pclk);
        chk("knob wake", 0, dark);
        repeat (10 * SEC + 20) @(posedge pclk);
        key(1);
        chk("key wake", 0, {dark, lbl});
        key(1);
        chk("second press", 1, lbl);
        repeat (10 * SEC + 20) @(posedge pclk);
        i_dwc_operator.talk(1, 0);
        repeat (6) @(posedge pclk);
        chk("tx wake", 0, dark);
        $display("test display done");
        print_verdict();
    end
endmodule : dwc_ctrl_test
`default_nettype wire

// file: tb/dwc_operator.sv
// Purpose: Operator model driving keys, knob and talk buttons.
// Assumes: Levels change just after a rising edge of pclk.
// Notes:   Bit order of lv: power, dual, set, arrow, cursor, up, down,
//          talk left, talk right.
`timescale 1ns/10ps
`default_nettype none
module dwc_operator (
    input  wire logic pclk,
    output logic      power_key,
    output logic      dual_watch_key,
    output logic      set_key,
    output logic      arrow_key,
    output logic      cursor_key,
    output logic      knob_up,
    output logic      knob_down,
    output logic      talk_left,
    output logic      talk_right
);
    logic [8:0] lv = 9'h000;  // Levels of all operator controls.
    assign {talk_right, talk_left, knob_down, knob_up, cursor_key,
            arrow_key, set_key, dual_watch_key, power_key} = lv;
    // Holds control k high for n cycles, then lets it go.
    task automatic press(input int k, input int n);
        @(posedge pclk);
        lv[k] <= 1'b1;
        repeat (n) @(posedge pclk);
        lv[k] <= 1'b0;
    endtask : press
    // Sets both talk buttons to new levels.
    task automatic talk(input logic l, input logic r);
        @(posedge pclk);
        lv[7] <= l;
        lv[8] <= r;
    endtask : talk
endmodule : dwc_operator
`default_nettype wire

// file: verilog/dwc_ctrl.sv
// Purpose: Dual watch, configuration menu, display saver and talk gating.
// Assumes: Keys and knob are raw pins; APB on pclk.
// Notes:   Keys are synchronised and edge detected before use; the set key level also times the menu hold.
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module dwc_ctrl
    import dwc_pkg::*;
#(
    parameter int unsigned MENU_HOLD = dwc_pkg::MENU_HOLD_CYC,
    parameter int unsigned MENU_TMO  = dwc_pkg::MENU_TMO_CYC,
    parameter int unsigned DW_PERIOD = dwc_pkg::DW_PERIOD_CYC,
    parameter int unsigned DW_DWELL  = dwc_pkg::DW_DWELL_CYC,
    parameter int unsigned SEC_CYC   = dwc_pkg::CLK_HZ
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        power_key,
    input  wire logic        dual_watch_key,
    input  wire logic        set_key,
    input  wire logic        arrow_key,
    input  wire logic        cursor_key,
    input  wire logic        knob_up,
    input  wire logic        knob_down,
    input  wire logic        talk_left,
    input  wire logic        talk_right,
    input  wire logic        intercom_in,
    input  wire logic        squelch_open,
    input  wire logic        chan_change,
    output logic             rx_on_standby,
    output logic             standby_channel_label,
    output logic             menu_active,
    output logic [3:0]       menu_item,
    output logic             display_dark,
    output logic             tx_key,
    output logic             mic_left_en,
    output logic             mic_right_en,
    output logic             intercom_out,
    output logic [3:0]       standby_atten,
    output logic             spacing_25k
);
    import dwc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers and edge detection.
    ////////////////////////////////////////////////////////////////////////
    localparam int NIN = 12;
    logic [NIN-1:0] raw_in;       // Raw asynchronous pins.
    logic [NIN-1:0] sync1_ff;     // First synchroniser stage.
    logic [NIN-1:0] sync2_ff;     // Second synchroniser stage.
    logic [NIN-1:0] prev_ff;      // Previous synchronised value.
    logic [NIN-1:0] rise;         // Rising edge strobes.
    assign raw_in = {chan_change, squelch_open, intercom_in, talk_right,
                     talk_left, knob_down, knob_up, cursor_key, arrow_key,
                     set_key, dual_watch_key, power_key};
    // Two flip-flops before any logic reads a pin.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            prev_ff  <= '0;
        end else begin
            sync1_ff <= raw_in;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end
    assign rise = sync2_ff & ~prev_ff;

    // Named views of the synchronised inputs.
    logic dw_p, set_lvl, set_fall, knob_p, pwr_p, exit_p, tl, tr, sq, chg_p;
    assign pwr_p    = rise[0];
    assign dw_p     = rise[1];
    assign set_lvl  = sync2_ff[2];
    assign set_fall = ~sync2_ff[2] & prev_ff[2];
    assign exit_p   = rise[0] | rise[1] | rise[3] | rise[4];
    assign knob_p   = rise[5] | rise[6];
    assign tl       = sync2_ff[7];
    assign tr       = sync2_ff[8];
    assign sq       = sync2_ff[10];
    assign chg_p    = rise[11];
    logic any_key_p;              // Any key other than power pressed.
    assign any_key_p = |rise[4:1] | rise[7] | rise[8];

    ////////////////////////////////////////////////////////////////////////
    // Registers written over APB.
    ////////////////////////////////////////////////////////////////////////
    logic [2:0] display_ff;       // Display saving code, 0 means never.
    logic [1:0] talk_ff;          // Talk button selection.
    logic [3:0] atten_ff;         // Standby attenuation magnitude 0..9.
    logic       spacing_ff;       // High selects 25 kHz raster only.
    logic [19:0] freq_ff;         // Last proposed frequency in kHz*... units.
    logic       freq_ok_ff;       // Last proposed frequency was accepted.
    logic       wr_en;            // Access phase of a write.
    assign wr_en   = psel & penable & pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel & penable &
                     (paddr != REG_CTRL) & (paddr != REG_STATUS) &
                     (paddr != REG_FREQ);

    // Settings change from APB writes or from the knob in the menu.
    logic menu_ff;
    logic [3:0] item_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            display_ff <= RST_DISPLAY;
            talk_ff    <= RST_TALK;
            atten_ff   <= RST_ATTEN;
            spacing_ff <= 1'b0;
        end else if (wr_en && paddr == REG_CTRL) begin
            display_ff <= (pwdata[2:0] > 3'h5) ? 3'h5 : pwdata[2:0];
            talk_ff    <= pwdata[5:4];
            atten_ff   <= (pwdata[11:8] > 4'h9) ? 4'h9 : pwdata[11:8];
            spacing_ff <= pwdata[12];
        end else if (menu_ff && knob_p && !display_dark) begin
            // The knob steps the value of the current item.
            unique case (item_ff)
                ITEM_SPACING: spacing_ff <= ~spacing_ff;
                ITEM_DISPLAY: display_ff <= (display_ff == 3'h5) ? 3'h0
                                            : display_ff + 3'h1;
                ITEM_TALK:    talk_ff    <= talk_ff + 2'h1;
                ITEM_ATTEN:   atten_ff   <= (atten_ff == 4'h9) ? 4'h0
                                            : atten_ff + 4'h1;
                default:      ;
            endcase
        end
    end

    // Frequency proposal check against spacing raster (value in kHz*1000/..).
    // Low two bits of the code: 0 marks a 25 kHz channel, others 8.33 kHz.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freq_ff    <= '0;
            freq_ok_ff <= 1'b0;
        end else if (wr_en && paddr == REG_FREQ) begin
            freq_ff    <= pwdata[19:0];
            freq_ok_ff <= !spacing_ff || (pwdata[1:0] == 2'h0);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration menu with hold entry and timeout.
    ////////////////////////////////////////////////////////////////////////
    logic [31:0] hold_ff;         // Set key hold counter.
    logic [31:0] tmo_ff;          // Menu inactivity counter.
    logic        held_ff;         // Hold already opened the menu.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_ff <= '0;
            held_ff <= 1'b0;
        end else if (!set_lvl) begin
            hold_ff <= '0;
            held_ff <= 1'b0;
        end else if (hold_ff < MENU_HOLD) begin
            hold_ff <= hold_ff + 32'h1;
        end else begin
            held_ff <= 1'b1;
        end
    end
    // Menu state, item index and timeout.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            menu_ff <= 1'b0;
            item_ff <= ITEM_SPACING;
            tmo_ff  <= '0;
        end else if (!menu_ff) begin
            tmo_ff <= '0;
            if (set_lvl && hold_ff == MENU_HOLD && !held_ff) begin
                menu_ff <= 1'b1;
                item_ff <= ITEM_SPACING;
            end
        end else if (exit_p && !display_dark) begin
            menu_ff <= 1'b0;
        end else if (tmo_ff >= MENU_TMO - 1) begin
            menu_ff <= 1'b0;
        end else if (set_fall && !held_ff && !display_dark) begin
            item_ff <= (item_ff == MENU_ITEMS - 4'h1) ? ITEM_SPACING
                       : item_ff + 4'h1;
            tmo_ff  <= '0;
        end else if (knob_p || any_key_p) begin
            tmo_ff <= '0;
        end else begin
            tmo_ff <= tmo_ff + 32'h1;
        end
    end
    assign menu_active = menu_ff;
    assign menu_item   = item_ff;

    ////////////////////////////////////////////////////////////////////////
    // Display saver.
    ////////////////////////////////////////////////////////////////////////
    logic [31:0] idle_ff;         // Idle time counter in cycles.
    logic        dark_ff;         // Display is darkened.
    logic [31:0] limit;           // Delay in cycles for the chosen code.
    logic        wake;            // Any wake event.
    always_comb begin
        unique case (display_ff)
            3'h1:    limit = DISP_S1 * SEC_CYC;
            3'h2:    limit = DISP_S2 * SEC_CYC;
            3'h3:    limit = DISP_S3 * SEC_CYC;
            3'h4:    limit = DISP_S4 * SEC_CYC;
            default: limit = DISP_S5 * SEC_CYC;
        endcase
    end
    assign wake = any_key_p | knob_p | tx_key;
    // Idle counts from last interaction; darkens at the limit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_ff <= '0;
            dark_ff <= 1'b0;
        end else if (wake || display_ff == 3'h0) begin
            idle_ff <= '0;
            dark_ff <= 1'b0;
        end else if (pwr_p && !dark_ff) begin
            // Power counts as use while lit but never wakes the display.
            idle_ff <= '0;
        end else if (idle_ff >= limit - 1) begin
            dark_ff <= 1'b1;
        end else begin
            idle_ff <= idle_ff + 32'h1;
        end
    end
    assign display_dark = dark_ff;

    ////////////////////////////////////////////////////////////////////////
    // Dual watch mode and receiver scheduling.
    ////////////////////////////////////////////////////////////////////////
    logic    dw_on_ff;            // Dual watch enabled.
    dwc_rx_e rx_ff;               // Receiver tuning state.
    logic [31:0] dwt_ff;          // Interval timer.
    // Key toggles the mode; channel change forces it off.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dw_on_ff <= 1'b0;
        end else if (chg_p) begin
            dw_on_ff <= 1'b0;
        end else if (dw_p && !display_dark && !menu_ff) begin
            dw_on_ff <= ~dw_on_ff;
        end
    end
    // Standby most of the time, peek at active each period.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_ff  <= DWC_RX_ACTIVE;
            dwt_ff <= '0;
        end else if (!dw_on_ff) begin
            rx_ff  <= DWC_RX_ACTIVE;
            dwt_ff <= '0;
        end else begin
            unique case (rx_ff)
                DWC_RX_ACTIVE, DWC_RX_STANDBY: begin
                    if (tx_key) begin
                        rx_ff <= DWC_RX_HOLD;
                    end else if (dwt_ff >= DW_PERIOD - 1) begin
                        rx_ff  <= DWC_RX_PEEK;
                        dwt_ff <= '0;
                    end else begin
                        rx_ff  <= DWC_RX_STANDBY;
                        dwt_ff <= dwt_ff + 32'h1;
                    end
                end
                DWC_RX_PEEK: begin
                    if (sq || tx_key) begin
                        rx_ff <= DWC_RX_HOLD;
                    end else if (dwt_ff >= DW_DWELL - 1) begin
                        rx_ff  <= DWC_RX_STANDBY;
                        dwt_ff <= '0;
                    end else begin
                        dwt_ff <= dwt_ff + 32'h1;
                    end
                end
                DWC_RX_HOLD: begin
                    dwt_ff <= '0;
                    if (!sq && !tx_key) begin
                        rx_ff <= DWC_RX_STANDBY;
                    end
                end
            endcase
        end
    end
    // Gated so that the receiver never shows standby while keyed or off.
    assign rx_on_standby         = dw_on_ff && !tx_key &&
                                   (rx_ff == DWC_RX_STANDBY);
    assign standby_channel_label = dw_on_ff;
    assign standby_atten         = atten_ff;
    assign spacing_25k           = spacing_ff;

    ////////////////////////////////////////////////////////////////////////
    // Talk button gating.
    ////////////////////////////////////////////////////////////////////////
    logic tx_ff, ml_ff, mr_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_ff <= 1'b0;
            ml_ff <= 1'b0;
            mr_ff <= 1'b0;
        end else begin
            unique case (dwc_talk_e'(talk_ff))
                DWC_TALK_ALL: begin
                    tx_ff <= tl | tr;
                    ml_ff <= tl | tr;
                    mr_ff <= tl | tr;
                end
                DWC_TALK_ONE: begin
                    tx_ff <= tl | tr;
                    ml_ff <= tl;
                    mr_ff <= tr;
                end
                DWC_TALK_LEFT: begin
                    tx_ff <= tl;
                    ml_ff <= tl;
                    mr_ff <= 1'b0;
                end
                DWC_TALK_RIGHT: begin
                    tx_ff <= tr;
                    ml_ff <= 1'b0;
                    mr_ff <= tr;
                end
            endcase
        end
    end
    assign tx_key       = tx_ff;
    assign mic_left_en  = ml_ff;
    assign mic_right_en = mr_ff;
    assign intercom_out = sync2_ff[9];

    ////////////////////////////////////////////////////////////////////////
    // APB read data.
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                REG_CTRL:   prdata <= {19'h0, spacing_ff, atten_ff, 2'h0,
                                       talk_ff, 1'b0, display_ff};
                REG_STATUS: prdata <= {22'h0, item_ff, rx_ff, dark_ff,
                                       menu_ff, tx_ff, dw_on_ff};
                REG_FREQ:   prdata <= {11'h0, freq_ok_ff, freq_ff};
                default:    prdata <= 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions.
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_tx_on_active: assert property (tx_key |-> !rx_on_standby)
        else $error("transmit while tuned to standby");
    a_hold_on_sq: assert property (
        rx_ff == DWC_RX_PEEK && sq |=> rx_ff == DWC_RX_HOLD)
        else $error("active signal did not hold receiver");
    a_label_follows: assert property (
        standby_channel_label == dw_on_ff && (dw_on_ff || !rx_on_standby))
        else $error("label or receiver wrong for mode");
    a_chg_clears_dw: assert property (chg_p |=> !dw_on_ff)
        else $error("channel change kept dual watch");
    a_left_only: assert property (
        talk_ff == DWC_TALK_LEFT && !tl |=> !tx_key && !mic_right_en)
        else $error("right side keyed in left only mode");
    a_atten_range: assert property (standby_atten <= 4'h9)
        else $error("attenuation out of range");
    a_one_mic: assert property (
        talk_ff == DWC_TALK_ONE && tl && !tr |=> !mic_right_en)
        else $error("wrong microphone in one mic mode");
    a_all_mics: assert property (
        talk_ff == DWC_TALK_ALL && tr |=> tx_key && mic_left_en)
        else $error("all mics mode failed to key");
    a_dark_wake: assert property (display_dark && knob_p |=> !display_dark)
        else $error("knob did not wake display");
    a_no_dark_never: assert property (display_ff == 3'h0 |=> !display_dark)
        else $error("display darkened with saver off");
endmodule : dwc_ctrl
`default_nettype wire
